// *** pkg/watchdog_pkg.sv ***
// Overview of operation
// - Refresh writes ignored while in debug mode
// - Debug entry clears the timer base counter
// - Post-debug extra delay below one count period
// - Watchdog counter frozen while in debug
// - Overflow raises NMI request, enters prewarning
// - Prewarning lasts 30 hex count units
// - Refresh during prewarning cannot stop reset
// - Reset flag set wins over register write
// - PLL divider survives a watchdog reset
package watchdog_pkg;
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] reload_offset = 8'h04;
  localparam logic [7:0] count_offset = 8'h08;
  localparam logic [7:0] power_offset = 8'h0C;
  localparam logic [7:0] nmi_offset = 8'h10;
  localparam logic [7:0] pll_offset = 8'h14;
  localparam logic [7:0] irq_status_offset = 8'h18;
  localparam logic [7:0] irq_enable_offset = 8'h1C;
  localparam logic [7:0] irq_clear_offset = 8'h20;
  localparam int ctrl_refresh_bit = 0;
  localparam int ctrl_enable_bit = 1;
  localparam int ctrl_debug_bit = 2;
  localparam int ctrl_prewarn_bit = 3;
  localparam int power_reset_flag_bit = 0;
  localparam logic [15:0] base_divide = 16'h00FF;
  localparam logic [15:0] prewarn_units = 16'h0030;
  localparam logic [15:0] count_max = 16'hFFFF;
  localparam logic [15:0] reload_reset = 16'h0000;
  localparam logic [7:0] pll_divider_reset = 8'h18;
  localparam logic [1:0] status_reset = 2'h0;
  typedef enum logic [1:0] {run_state, prewarn_state} wd_state_type;
endpackage

// *** hdl/watchdog_prewarning_debug.sv ***
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module watchdog_prewarning_debug
  import watchdog_pkg::*;
(
  // System
  input wire logic clock,
  input wire logic resetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Debug and system
  input wire logic debug_mode,
  output logic watchdog_nmi,
  output logic watchdog_reset_out,
  output logic [7:0] pll_feedback_divider,
  output logic irq
);
  logic [7:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic w_have_reg;
  logic w_low_strb_reg;
  logic [15:0] base_reg;
  logic [15:0] watchdog_counter;
  logic [15:0] reload_reg;
  logic [15:0] prewarn_reg;
  logic enable_reg;
  logic watchdog_reset_flag;
  logic watchdog_nmi_enable;
  logic debug_reg;
  logic [1:0] status_reg;
  logic [1:0] irq_enable_reg;
  wd_state_type state_reg;
  logic wr_fire;
  logic tick;
  logic refresh;
  logic overflow;
  logic prewarn_done;
  logic [31:0] rd_value;

  assign wr_fire = aw_have_reg && w_have_reg && !bvalid;

  // Write address and data are latched independently so either order works
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      awready <= 1'b0;
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end
    else
    begin
      awready <= !aw_have_reg && !awready && awvalid;
      if (awvalid && awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      else if (wr_fire)
        aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      wready <= 1'b0;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_low_strb_reg <= 1'b0;
    end
    else
    begin
      wready <= !w_have_reg && !wready && wvalid;
      if (wvalid && wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= wdata;
        // Strobe is payload of the data channel; the master may drop it after the handshake
        w_low_strb_reg <= wstrb[0];
      end
      else if (wr_fire)
        w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      bresp <= (aw_addr_reg > irq_clear_offset || aw_addr_reg[1:0] != 2'h0) ? 2'h2 : 2'h0;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // Debug suppresses refresh; prewarning writes are ignored too so reset still follows
  assign refresh = wr_fire && aw_addr_reg == ctrl_offset && w_low_strb_reg && w_data_reg[ctrl_refresh_bit]
                   && !debug_mode && state_reg == run_state;

  // Base divider is cleared on debug entry; costs under one count period afterwards
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      base_reg <= 16'h0000;
    else if (debug_mode)
      base_reg <= 16'h0000;
    else if (base_reg == base_divide)
      base_reg <= 16'h0000;
    else
      base_reg <= base_reg + 16'h0001;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      debug_reg <= 1'b0;
    else
      debug_reg <= debug_mode;
  end

  assign tick = enable_reg && !debug_mode && base_reg == base_divide;
  // A refresh landing on the overflow tick wins, so no prewarning is entered then
  assign overflow = tick && state_reg == run_state && watchdog_counter == count_max && !refresh;
  assign prewarn_done = tick && state_reg == prewarn_state && prewarn_reg == prewarn_units - 16'h0001;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= run_state;
      watchdog_counter <= reload_reset;
      prewarn_reg <= 16'h0000;
      watchdog_nmi <= 1'b0;
      watchdog_reset_out <= 1'b0;
    end
    else
    begin
      watchdog_reset_out <= prewarn_done;
      unique case (state_reg)
        run_state:
        begin
          if (refresh)
            watchdog_counter <= reload_reg;
          else if (overflow)
          begin
            state_reg <= prewarn_state;
            prewarn_reg <= 16'h0000;
            watchdog_nmi <= 1'b1;
          end
          else if (tick)
            watchdog_counter <= watchdog_counter + 16'h0001;
        end
        prewarn_state:
        begin
          if (prewarn_done)
          begin
            state_reg <= run_state;
            watchdog_nmi <= 1'b0;
            watchdog_counter <= reload_reg;
          end
          else if (tick)
            prewarn_reg <= prewarn_reg + 16'h0001;
        end
      endcase
    end
  end

  // Control registers; the watchdog reset leaves the PLL divider alone
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      enable_reg <= 1'b0;
      reload_reg <= reload_reset;
      watchdog_nmi_enable <= 1'b0;
      pll_feedback_divider <= pll_divider_reset;
      irq_enable_reg <= status_reset;
    end
    else if (wr_fire && w_low_strb_reg)
    begin
      unique case (aw_addr_reg)
        ctrl_offset: enable_reg <= w_data_reg[ctrl_enable_bit];
        reload_offset: reload_reg <= w_data_reg[15:0];
        nmi_offset: watchdog_nmi_enable <= w_data_reg[0];
        pll_offset: pll_feedback_divider <= w_data_reg[7:0];
        irq_enable_offset: irq_enable_reg <= w_data_reg[1:0];
        default: ;
      endcase
    end
  end

  // Hardware set beats software write in the same cycle
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      watchdog_reset_flag <= 1'b0;
    else if (prewarn_done)
      watchdog_reset_flag <= 1'b1;
    else if (wr_fire && w_low_strb_reg && aw_addr_reg == power_offset)
      watchdog_reset_flag <= w_data_reg[power_reset_flag_bit];
  end

  // Status: bit0 prewarning entered, bit1 watchdog reset
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      status_reg <= status_reset;
    else
      status_reg <= (status_reg & ~((wr_fire && w_low_strb_reg && aw_addr_reg == irq_clear_offset)
                                    ? w_data_reg[1:0] : 2'h0)) | {prewarn_done, overflow};
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(status_reg & irq_enable_reg);
  end

  always_comb
  begin
    rd_value = 32'h00000000;
    unique case (araddr)
      ctrl_offset: rd_value = {28'h0000000, state_reg == prewarn_state, debug_reg, enable_reg, 1'b0};
      reload_offset: rd_value = {16'h0000, reload_reg};
      count_offset: rd_value = {16'h0000, watchdog_counter};
      power_offset: rd_value = {31'h00000000, watchdog_reset_flag};
      nmi_offset: rd_value = {31'h00000000, watchdog_nmi_enable};
      pll_offset: rd_value = {24'h000000, pll_feedback_divider};
      irq_status_offset: rd_value = {30'h00000000, status_reg};
      irq_enable_offset: rd_value = {30'h00000000, irq_enable_reg};
      default: rd_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end
    else
    begin
      arready <= !arready && !rvalid && arvalid;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata <= rd_value;
        rresp <= (araddr > irq_clear_offset || araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  debug_refresh_a: assert property (@(posedge clock) disable iff (!resetn)
    debug_mode && state_reg == run_state && !tick |=> watchdog_counter == $past(watchdog_counter))
    else $error("counter moved during debug");
  debug_clear_a: assert property (@(posedge clock) disable iff (!resetn)
    debug_mode |=> base_reg == 16'h0000)
    else $error("base counter not cleared in debug");
  extra_delay_a: assert property (@(posedge clock) disable iff (!resetn)
    base_reg <= base_divide)
    else $error("base counter beyond one period");
  debug_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    debug_mode |-> !tick)
    else $error("tick during debug");
  overflow_nmi_a: assert property (@(posedge clock) disable iff (!resetn)
    overflow |=> watchdog_nmi && state_reg == prewarn_state)
    else $error("overflow without nmi");
  prewarn_len_a: assert property (@(posedge clock) disable iff (!resetn)
    state_reg == prewarn_state |-> prewarn_reg < prewarn_units)
    else $error("prewarning too long");
  prewarn_reset_a: assert property (@(posedge clock) disable iff (!resetn)
    prewarn_done |=> watchdog_reset_out && state_reg == run_state)
    else $error("no reset after prewarning");
  reset_flag_a: assert property (@(posedge clock) disable iff (!resetn)
    prewarn_done |=> watchdog_reset_flag)
    else $error("reset flag not set");
  pll_keep_a: assert property (@(posedge clock) disable iff (!resetn)
    watchdog_reset_out |-> pll_feedback_divider == $past(pll_feedback_divider))
    else $error("divider changed at watchdog reset");
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb
  import watchdog_pkg::*;
;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic debug_mode = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, watchdog_nmi, watchdog_reset_out, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, v, c1;
  logic [7:0] pll_feedback_divider;
  int num_errors = 0, n_compared = 0, i;
  time t0;
  always #5 clock = ~clock;
  watchdog_prewarning_debug uut (.clock(clock), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .debug_mode(debug_mode),
    .watchdog_nmi(watchdog_nmi), .watchdog_reset_out(watchdog_reset_out),
    .pll_feedback_divider(pll_feedback_divider), .irq(irq));
  task report_and_stop;
    $display("Checked %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Each channel is released at the edge where its own ready is sampled
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge clock);
      if (awready === 1'b1)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1)
      begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clock);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  initial
  begin
    // Bound covers the full scenario with a wide margin
    repeat (60000) @(posedge clock);
    num_errors++;
    report_and_stop;
  end
  initial
  begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk("pll_port", pll_feedback_divider, pll_divider_reset);
    chk("nmi", watchdog_nmi, 1'b0);
    rd(power_offset); chk("power", v, 32'h0);
    rd(pll_offset); chk("pll", v, 32'h18);
    rd(irq_status_offset); chk("status", v, 32'h0);
    rd(8'h24); chk("bad_rd", {resp, v[29:0]}, 32'h80000000);
    wr(8'h28, 32'h1); chk("bad_wr", resp, 2'h2);
    rd(8'h02); chk("misaligned", {resp, v[29:0]}, 32'h80000000);
    // Without the low strobe a write must leave the register untouched
    wstrb <= 4'hE;
    wr(reload_offset, 32'h1234);
    wstrb <= 4'hF;
    rd(reload_offset); chk("strb_gate", v, 32'h0);
    wr(reload_offset, 32'hFFF0);
    wr(ctrl_offset, 32'h3);
    repeat (600) @(posedge clock);
    debug_mode <= 1'b1;
    repeat (4) @(posedge clock);
    rd(ctrl_offset); chk("dbg_bit", v[ctrl_debug_bit], 1'b1);
    rd(count_offset);
    c1 = v;
    wr(ctrl_offset, 32'h3);
    repeat (600) @(posedge clock);
    rd(count_offset); chk("frozen", v, c1);
    @(posedge clock);
    debug_mode <= 1'b0;
    t0 = $time;
    // Cleared base means the first tick after exit takes one full unit
    for (i = 0; i < 100 && v === c1; i++) rd(count_offset);
    chk("exit_gap", (($time - t0) / 10) inside {[240:300]}, 1'b1);
    wr(irq_enable_offset, 32'h1);
    wr(pll_offset, 32'h22);
    wr(nmi_offset, 32'h1);
    rd(nmi_offset); chk("nmi_en", v, 32'h1);
    for (i = 0; i < 6000 && watchdog_nmi !== 1'b1; i++) @(posedge clock);
    chk("nmi_on", watchdog_nmi, 1'b1);
    t0 = $time;
    repeat (3) @(posedge clock);
    chk("irq_on", irq, 1'b1);
    rd(ctrl_offset); chk("prewarn", v[ctrl_prewarn_bit], 1'b1);
    // Refresh attempts during prewarning must not stop the reset
    for (i = 0; i < 3; i++) wr(ctrl_offset, 32'h3);
    for (i = 0; i < 14000 && watchdog_reset_out !== 1'b1; i++) @(posedge clock);
    chk("rst_pulse", watchdog_reset_out, 1'b1);
    chk("pw_len", (($time - t0) / 10) inside {[12032:12544]}, 1'b1);
    @(posedge clock);
    chk("pulse_1cyc", watchdog_reset_out, 1'b0);
    rd(power_offset); chk("rst_flag", v[power_reset_flag_bit], 1'b1);
    rd(irq_status_offset); chk("status2", v, 32'h3);
    rd(pll_offset); chk("pll_kept", v, 32'h22);
    chk("pll_port2", pll_feedback_divider, 8'h22);
    wr(pll_offset, 32'h2A); chk("pll_reprog", pll_feedback_divider, 8'h2A);
    wr(irq_enable_offset, 32'h0);
    repeat (3) @(posedge clock);
    chk("irq_mask", irq, 1'b0);
    wr(irq_clear_offset, 32'h3);
    rd(irq_status_offset); chk("cleared", v, 32'h0);
    report_and_stop;
  end
endmodule
